/* common/hpsc_pkg.sv */
// Constants and types for the host port strobe and chip-select block
// Assumes one 50 MHz clock and host pins that are asynchronous to it
// What this block does
// - Separate-strobe mode: read strobe low drives the addressed data onto the bus.
// - Separate-strobe mode: data bus released once the read strobe goes high.
// - Direction mode: shared strobe times transfers, a separate input gives direction.
// - Synchronous mode: host-clock rise with enable and select low, write high captures data.
// - Separate-strobe mode: address latch enable starts a cycle, address taken on its fall.
// - Direction mode: direction high at data strobe fall is a read, else write.
// - Synchronous mode: select low at host-clock rise takes address; low direction reads.
// - Synchronous mode: after the strap sets ready low, it changes only on host-clock rising edges.
package hpsc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PIN_W = 28;
  // ==========================================================
  // Bit positions in the synchronised pin bundle
  localparam int POS_ADDR = 0;
  localparam int POS_DATA = 15;
  localparam int POS_STB = 23;
  localparam int POS_WRD = 24;
  localparam int POS_ASTB = 25;
  localparam int POS_CS = 26;
  localparam int POS_HCLK = 27;
  // Idle pin levels: read and write strobes and select high, address strobe low
  localparam logic [PIN_W-1:0] PIN_RST = 28'h580_0000;
  // ==========================================================
  // Mode configuration codes
  localparam logic [1:0] CFG_SEP = 2'h0;
  localparam logic [1:0] CFG_DIR = 2'h1;
  localparam logic [1:0] CFG_SYN = 2'h2;
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  typedef enum logic [2:0] {
    MODE_SEP = 3'b001,
    MODE_DIR = 3'b010,
    MODE_SYN = 3'b100
  } hpsc_mode_type;
endpackage

/* common/hpsc_pin_if.sv */
// Interface carrying the raw and filtered host pin bundle
// Assumes the bundle layout of the package
`timescale 1ns/10ps
interface hpsc_pin_if;
  logic [hpsc_pkg::PIN_W-1:0] raw;
  logic [hpsc_pkg::PIN_W-1:0] clean;
  modport sync_mp (input raw, output clean);
  modport user_mp (output raw, input clean);
endinterface

/* verilog/hpsc_sync.sv */
// Three-stage pin synchroniser with agreement filter
// Assumes raw pins asynchronous to clock_i
`timescale 1ns/10ps
module hpsc_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Pin bundle
  hpsc_pin_if.sync_mp pins
);
  import hpsc_pkg::*;
  // ==========================================================
  // Per-bit stages
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic cl_r;
      logic cl_nxt;
      always_comb begin
        cl_nxt = (s2_r == s3_r) ? s2_r : cl_r;
      end
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          s1_r <= PIN_RST[gi];
          s2_r <= PIN_RST[gi];
          s3_r <= PIN_RST[gi];
          cl_r <= PIN_RST[gi];
        end else begin
          s1_r <= pins.raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          cl_r <= cl_nxt;
        end
      end
      assign pins.clean[gi] = cl_r;
    end
  endgenerate
endmodule // hpsc_sync

/* verilog/hpsc_top.sv */
// Host port strobe, address latch and chip-select decode
// Assumes host pins asynchronous; register file answers on reg_* ports
`timescale 1ns/10ps
module hpsc_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Static mode strap
  input wire logic [1:0] mode_cfg_i,
  // Host pins
  input wire logic [hpsc_pkg::ADDR_W-1:0] addr_pin_i,
  input wire logic [hpsc_pkg::DATA_W-1:0] data_pin_i,
  output logic [hpsc_pkg::DATA_W-1:0] data_pin_o,
  output logic data_oe_o,
  input wire logic read_data_write_strobe_pin_i,
  input wire logic write_dir_pin_i,
  input wire logic address_strobe_pin_i,
  input wire logic chip_select_pin_i,
  input wire logic host_clock_pin_i,
  output logic ready_o,
  // Register file side
  output logic [hpsc_pkg::ADDR_W-1:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [hpsc_pkg::DATA_W-1:0] reg_wr_data_o,
  input wire logic [hpsc_pkg::DATA_W-1:0] reg_rd_data_i,
  input wire logic reg_rdy_i
);
  import hpsc_pkg::*;
  // ==========================================================
  // Pin synchroniser
  hpsc_pin_if pin_bus ();
  assign pin_bus.raw = {host_clock_pin_i, chip_select_pin_i, address_strobe_pin_i,
                        write_dir_pin_i, read_data_write_strobe_pin_i, data_pin_i, addr_pin_i};
  hpsc_sync u_sync (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .pins (pin_bus.sync_mp)
  );
  logic [PIN_W-1:0] c;
  logic [PIN_W-1:0] prev_r;
  logic [ADDR_W-1:0] c_addr;
  logic [DATA_W-1:0] c_data;
  assign c = pin_bus.clean;
  assign c_addr = c[POS_ADDR +: ADDR_W];
  assign c_data = c[POS_DATA +: DATA_W];
  // Edges of filtered pins
  logic stb_fall, stb_rise, wrd_rise, astb_fall, astb_rise, hclk_rise, sel;
  assign stb_fall = prev_r[POS_STB] & ~c[POS_STB];
  assign stb_rise = ~prev_r[POS_STB] & c[POS_STB];
  assign wrd_rise = ~prev_r[POS_WRD] & c[POS_WRD];
  assign astb_fall = prev_r[POS_ASTB] & ~c[POS_ASTB];
  assign astb_rise = ~prev_r[POS_ASTB] & c[POS_ASTB];
  assign hclk_rise = ~prev_r[POS_HCLK] & c[POS_HCLK];
  assign sel = ~c[POS_CS];
  // ==========================================================
  // Port state
  hpsc_mode_type mode_r, mode_nxt;
  logic done_r, done_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdat_r, wdat_nxt, dout_r, dout_nxt;
  logic rd_r, rd_nxt, wr_r, wr_nxt, oe_r, oe_nxt, rdy_r, rdy_nxt, dirrd_r, dirrd_nxt;
  logic dir_now;
  always_comb begin
    mode_nxt = mode_r;
    done_nxt = done_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    dout_nxt = reg_rd_data_i;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    oe_nxt = 1'b0;
    rdy_nxt = rdy_r;
    dirrd_nxt = dirrd_r;
    dir_now = stb_fall ? c[POS_WRD] : dirrd_r;
    if (!done_r) begin
      // Strap taken once after reset release
      done_nxt = 1'b1;
      unique case (mode_cfg_i)
        CFG_DIR: mode_nxt = MODE_DIR;
        CFG_SYN: mode_nxt = MODE_SYN;
        default: mode_nxt = MODE_SEP;
      endcase
      rdy_nxt = (mode_cfg_i != CFG_SYN);
    end else begin
      unique case (mode_r)
        MODE_SEP: begin
          if (astb_fall) addr_nxt = c_addr;
          if (sel && stb_fall) rd_nxt = 1'b1;
          oe_nxt = sel && !c[POS_STB];
          if (sel && wrd_rise) begin
            wr_nxt = 1'b1;
            wdat_nxt = c_data;
          end
          rdy_nxt = !(sel && (!c[POS_STB] || !c[POS_WRD]) && reg_rdy_i);
        end
        MODE_DIR: begin
          if (astb_rise) addr_nxt = c_addr;
          if (sel && stb_fall) begin
            dirrd_nxt = c[POS_WRD];
            rd_nxt = c[POS_WRD];
          end
          oe_nxt = sel && !c[POS_STB] && dir_now;
          if (sel && stb_rise && !dirrd_r) begin
            wr_nxt = 1'b1;
            wdat_nxt = c_data;
          end
          rdy_nxt = !(sel && !c[POS_STB] && reg_rdy_i);
        end
        MODE_SYN: begin
          if (hclk_rise) begin
            if (sel) begin
              addr_nxt = c_addr;
              dirrd_nxt = !c[POS_WRD];
              rd_nxt = !c[POS_WRD];
            end
            if (sel && !c[POS_STB] && c[POS_WRD]) begin
              wr_nxt = 1'b1;
              wdat_nxt = c_data;
            end
            rdy_nxt = sel && reg_rdy_i;
          end
          // Deselect ends the read drive
          if (!sel) dirrd_nxt = 1'b0;
          oe_nxt = sel && dirrd_r;
        end
      endcase
    end
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= PIN_RST;
      mode_r <= MODE_SEP;
      done_r <= 1'b0;
      addr_r <= ADDR_RST;
      wdat_r <= DATA_RST;
      dout_r <= DATA_RST;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      oe_r <= 1'b0;
      rdy_r <= 1'b1;
      dirrd_r <= 1'b0;
    end else begin
      prev_r <= c;
      mode_r <= mode_nxt;
      done_r <= done_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      dout_r <= dout_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      oe_r <= oe_nxt;
      rdy_r <= rdy_nxt;
      dirrd_r <= dirrd_nxt;
    end
  end
  assign data_pin_o = dout_r;
  assign data_oe_o = oe_r;
  assign ready_o = rdy_r;
  assign reg_addr_o = addr_r;
  assign reg_rd_o = rd_r;
  assign reg_wr_o = wr_r;
  assign reg_wr_data_o = wdat_r;
  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic sep_on, dir_on, syn_on;
  assign sep_on = done_r && mode_r == MODE_SEP;
  assign dir_on = done_r && mode_r == MODE_DIR;
  assign syn_on = done_r && mode_r == MODE_SYN;
  sequence sep_rd_start;
    sep_on && sel && stb_fall;
  endsequence
  sequence sep_rd_answer;
    data_oe_o && reg_rd_o;
  endsequence
  sep_read_drive_a: assert property (sep_rd_start |=> sep_rd_answer)
    else $error("read strobe did not drive bus");
  sep_release_a: assert property (sep_on && c[POS_STB] |=> !data_oe_o)
    else $error("bus not released after read strobe");
  dir_write_a: assert property (dir_on && sel && stb_rise && !dirrd_r
    |=> reg_wr_o && reg_wr_data_o == $past(c_data))
    else $error("data strobe write not captured");
  syn_write_a: assert property (syn_on && hclk_rise && sel && !c[POS_STB] && c[POS_WRD]
    |=> reg_wr_o && reg_wr_data_o == $past(c_data))
    else $error("synchronous write not captured");
  sep_addr_a: assert property (sep_on && astb_fall |=> reg_addr_o == $past(c_addr))
    else $error("latch enable fall did not take address");
  dir_addr_a: assert property (dir_on && astb_rise |=> reg_addr_o == $past(c_addr))
    else $error("address strobe rise did not take address");
  dir_read_a: assert property (dir_on && sel && stb_fall
    |=> reg_rd_o == $past(c[POS_WRD]))
    else $error("direction decode wrong");
  syn_addr_a: assert property (syn_on && hclk_rise && sel
    |=> reg_addr_o == $past(c_addr) && reg_rd_o == !$past(c[POS_WRD]))
    else $error("synchronous address or direction wrong");
  sep_write_a: assert property (sep_on && sel && wrd_rise
    |=> reg_wr_o ##1 !reg_wr_o)
    else $error("write strobe rise not a single write");
  syn_ready_a: assert property (syn_on && !hclk_rise |=> $stable(ready_o))
    else $error("ready moved off host-clock edge");
  mode_hold_a: assert property (done_r |=> $stable(mode_r) && done_r)
    else $error("bus mode changed");
  no_select_a: assert property (done_r && !sel |=> !reg_wr_o && !reg_rd_o)
    else $error("access without chip select");
  syn_deselect_a: assert property (syn_on && !sel |=> !data_oe_o)
    else $error("bus driven while deselected");
endmodule // hpsc_top

/* verif/hpsc_host_model.sv */
// Host processor model driving address, strobes, select and data
// Assumes the bench resolves the data bus from the design's drive enable alone
`timescale 1ns/10ps
module hpsc_host_model (
  // Clock
  input wire logic clock_i,
  // Host pins
  output logic [hpsc_pkg::ADDR_W-1:0] addr_o,
  output logic [hpsc_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic strobe_n_o,
  output logic wrd_o,
  output logic astb_o,
  output logic cs_n_o,
  output logic hclk_o
);
  import hpsc_pkg::*;
  initial begin
    addr_o = ADDR_RST;
    data_o = DATA_RST;
    data_oe_o = 1'b0;
    strobe_n_o = 1'b1;
    wrd_o = 1'b1;
    astb_o = 1'b0;
    cs_n_o = 1'b1;
    hclk_o = 1'b0;
  end
  // Idle level of the address strobe pin between scenarios
  task automatic park;
    astb_o = 1'b0;
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  // ==========================================
  // One access in the selected bus mode
  task automatic access(input logic [1:0] m, input logic wr, input logic sel,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr_o = a;
    astb_o = (m == CFG_SEP);
    hold(6);
    astb_o = (m == CFG_DIR);
    hold(6);
    cs_n_o = !sel;
    wrd_o = (m == CFG_SEP) ? !wr : (m == CFG_DIR) ? !wr : wr;
    data_o = d;
    data_oe_o = wr;
    hold(2);
    strobe_n_o = (m == CFG_SEP && wr) || (m == CFG_SYN && !wr);
    hclk_o = (m == CFG_SYN);
    hold(8);
    strobe_n_o = 1'b1;
    wrd_o = 1'b1;
    hclk_o = 1'b0;
    hold(6);
    data_oe_o = 1'b0;
    data_o = ~d;
    cs_n_o = 1'b1;
    hold(6);
  endtask
endmodule // hpsc_host_model

/* verif/tb.sv */
// Self-checking bench for the host port strobe block
// Assumes the host model and the design top under test
`timescale 1ns/10ps
module tb;
  import hpsc_pkg::*;
  logic clock_i, rst_i, oe, stb, wrd, astb, cs_n, hclk, rdy_i;
  logic [1:0] mode_cfg;
  logic [ADDR_W-1:0] addr, reg_addr;
  logic [DATA_W-1:0] hdata, dout_w, dout, wdata, rd_data;
  logic data_oe, ready, rd, wr, oe_seen, rdy_lo, clash;
  int n_rd, n_wr, cycles, fails, checks_done;
  hpsc_host_model u_hpsc_host_model (.clock_i(clock_i), .addr_o(addr), .data_o(hdata),
    .data_oe_o(oe), .strobe_n_o(stb), .wrd_o(wrd), .astb_o(astb), .cs_n_o(cs_n),
    .hclk_o(hclk));
  hpsc_top u_hpsc_top (.clock_i(clock_i), .rst_i(rst_i), .mode_cfg_i(mode_cfg),
    .addr_pin_i(addr), .data_pin_i(data_oe ? dout_w : hdata), .data_pin_o(dout_w),
    .data_oe_o(data_oe), .read_data_write_strobe_pin_i(stb), .write_dir_pin_i(wrd),
    .address_strobe_pin_i(astb), .chip_select_pin_i(cs_n), .host_clock_pin_i(hclk),
    .ready_o(ready), .reg_addr_o(reg_addr), .reg_rd_o(rd), .reg_wr_o(wr),
    .reg_wr_data_o(wdata), .reg_rd_data_i(rd_data), .reg_rdy_i(rdy_i));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // ==========================================
  // Monitor and timeout
  always @(negedge clock_i) begin
    cycles <= cycles + 1;
    if (data_oe === 1'b1 && oe === 1'b1) clash <= 1'b1;
    if (rd === 1'b1) n_rd <= n_rd + 1;
    if (wr === 1'b1) n_wr <= n_wr + 1;
    if (ready === 1'b0) rdy_lo <= 1'b1;
    if (data_oe === 1'b1) begin
      oe_seen <= 1'b1;
      dout <= dout_w;
    end
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reset_to(input logic [1:0] m);
    u_hpsc_host_model.park();
    rst_i = 1'b1;
    mode_cfg = m;
    repeat (5) @(posedge clock_i);
    #2;
    rst_i = 1'b0;
    repeat (6) @(posedge clock_i);
    #2;
  endtask
  task automatic xfer(input logic [1:0] m, input logic w, input logic sel,
                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    n_rd = 0;
    n_wr = 0;
    oe_seen = 1'b0;
    rdy_lo = 1'b0;
    clash = 1'b0;
    rd_data = a[DATA_W-1:0] ^ 8'h3c;
    u_hpsc_host_model.access(m, w, sel, a, d);
    check("reads", n_rd, 32'(sel && !w));
    check("writes", n_wr, 32'(sel && w));
    if (sel) check("address", 32'(reg_addr), 32'(a));
    if (sel && w) check("wdata", 32'(wdata), 32'(d));
    check("drive", 32'(oe_seen), 32'(sel && !w));
    if (sel && !w) check("rdata", 32'(dout), 32'(rd_data));
    check("released", 32'(data_oe), 32'h0);
    check("clash", 32'(clash), 32'h0);
  endtask
  // ==========================================
  // Scenarios
  task automatic sc_sep;
    reset_to(CFG_SEP);
    xfer(CFG_SEP, 1'b0, 1'b1, 15'h7fff, 8'h00);
    check("ready low", 32'(rdy_lo), 32'h1);
    xfer(CFG_SEP, 1'b1, 1'b1, 15'h0001, 8'h5a);
    xfer(CFG_SEP, 1'b0, 1'b0, 15'h0002, 8'h00);
    xfer(CFG_SEP, 1'b1, 1'b1, 15'h0003, 8'hff);
  endtask
  task automatic sc_strap3;
    reset_to(2'h3);
    mode_cfg = CFG_SYN;
    xfer(CFG_SEP, 1'b1, 1'b1, 15'h1234, 8'h3c);
  endtask
  task automatic sc_dir;
    reset_to(CFG_DIR);
    xfer(CFG_DIR, 1'b0, 1'b1, 15'h4000, 8'h00);
    xfer(CFG_DIR, 1'b1, 1'b1, 15'h2aaa, 8'ha5);
    xfer(CFG_DIR, 1'b1, 1'b0, 15'h0555, 8'h11);
  endtask
  task automatic sc_syn;
    reset_to(CFG_SYN);
    xfer(CFG_SYN, 1'b0, 1'b1, 15'h0f0f, 8'h00);
    check("ready hi", 32'(ready), 32'h1);
    rdy_i = 1'b0;
    xfer(CFG_SYN, 1'b1, 1'b1, 15'h7ffe, 8'h81);
    check("ready lo", 32'(ready), 32'h0);
    rdy_i = 1'b1;
    xfer(CFG_SYN, 1'b1, 1'b0, 15'h0100, 8'h22);
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    mode_cfg = CFG_SEP;
    rd_data = 8'hc3;
    rdy_i = 1'b1;
    cycles = 0;
    fails = 0;
    checks_done = 0;
    sc_sep();
    sc_strap3();
    sc_dir();
    sc_syn();
    stop_test();
  end
endmodule // tb
